// File: include/gppw_pkg.sv
// Constants, types and reset values for the general-purpose pad control block.
// Assumes one system clock and one active-low reset; ports are held in 8-bit lanes.
//
// Functional notes
// - Every pin of each port is separately set as input or output by software.
// - Each pin separately selects pull-up or pull-down and enables or disables it.
// - Analog, C, P, T and U ports leave reset with all pulls disabled.
// - Ports A, B, D, E, F, G, H leave reset with pull-downs enabled.
// - Port J leaves reset with its four pull-downs disabled.
// - Port S leaves reset with all eight pull-ups enabled.
// - Analog, S and T pins can each be enabled as wake-up interrupt inputs.
// - Each port S pin can drive open-drain instead of push-pull.
// - Each port U pin has a separately enabled slew-rate control.
package gppw_pkg;

    // ------------------------------------------------------------
    // Port numbering
    // ------------------------------------------------------------
    localparam int GPPW_NPORT = 14;
    localparam int GPPW_W = 8;
    localparam int GPPW_P_ANALOG = 0;
    localparam int GPPW_P_A = 1;
    localparam int GPPW_P_B = 2;
    localparam int GPPW_P_C = 3;
    localparam int GPPW_P_D = 4;
    localparam int GPPW_P_E = 5;
    localparam int GPPW_P_F = 6;
    localparam int GPPW_P_J = 7;
    localparam int GPPW_P_G = 8;
    localparam int GPPW_P_H = 9;
    localparam int GPPW_P_P = 10;
    localparam int GPPW_P_S = 11;
    localparam int GPPW_P_T = 12;
    localparam int GPPW_P_U = 13;

    // ------------------------------------------------------------
    // Pins that exist in each lane (four-pin ports use bits 3:0)
    // ------------------------------------------------------------
    localparam logic [13:0][7:0] GPPW_PIN_MASK = {
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f,
        8'hff, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff
    };

    // ------------------------------------------------------------
    // Pull reset values, index 13 (U) down to 0 (analog)
    // ------------------------------------------------------------
    localparam logic [13:0][7:0] GPPW_PEN_RST = {
        8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00,
        8'hff, 8'h0f, 8'hff, 8'h00, 8'h0f, 8'hff, 8'h00
    };
    localparam logic [13:0][7:0] GPPW_PUP_RST = {
        8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
    };

    // Feature presence per port
    localparam logic [13:0] GPPW_HAS_WAKE = 14'h1801;
    localparam logic [13:0] GPPW_HAS_OD = 14'h0800;
    localparam logic [13:0] GPPW_HAS_SLEW = 14'h2000;

    // Generic reset value for all other per-pin fields
    localparam logic [7:0] GPPW_ZERO_RST = 8'h00;

    // ------------------------------------------------------------
    // Configuration field selector
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        GPPW_F_DATA = 3'h0,
        GPPW_F_DIR = 3'h1,
        GPPW_F_PEN = 3'h2,
        GPPW_F_PUP = 3'h3,
        GPPW_F_WEN = 3'h4,
        GPPW_F_WPOL = 3'h5,
        GPPW_F_OD = 3'h6,
        GPPW_F_SLEW = 3'h7
    } gppw_field_t;

    // Per-port register set
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] dir;
        logic [7:0] pen;
        logic [7:0] pup;
        logic [7:0] wen;
        logic [7:0] wpol;
        logic [7:0] od;
        logic [7:0] slew;
        logic [7:0] prev;
        logic [7:0] flag;
    } gppw_port_t;

endpackage

// File: include/gppw_sync_if.sv
// Carrier between the pad control top and its two-stage synchroniser.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface gppw_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] synced;

    modport sync_end (
        input raw,
        output synced
    );
    modport user_end (
        output raw,
        input synced
    );
endinterface

// File: design/gppw_sync.sv
// Two flip-flop synchroniser for any width, reset to zero.
// Assumes raw may change at any time relative to clk.
`timescale 1ns/1ps
module gppw_sync
    import gppw_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    gppw_sync_if.sync_end s
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } gppw_sync_st_t;

    gppw_sync_st_t st_q;
    gppw_sync_st_t st_d;

    // First stage feeds only the second stage
    always_comb begin
        st_d.meta = s.raw;
        st_d.stable = st_q.meta;
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign s.synced = st_q.stable;
endmodule

// File: design/gppw_pad_ctrl.sv
// Per-pin direction, pull, open-drain, slew and wake-up logic for all ports.
// Assumes pad cells act on the enables below and pad inputs are asynchronous.
// Limitation: a pad pulse shorter than one clock may never reach the wake logic.
// A field written to a port that lacks it lands as zero, so it never switches on.
// Wake flags are cleared per pin through wake_clr; the request lines follow them.
`timescale 1ns/1ps
module gppw_pad_ctrl
    import gppw_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [13:0] cfg_wr,
    input wire gppw_field_t cfg_sel,
    input wire logic [7:0] cfg_wdata,
    input wire logic [13:0][7:0] wake_clr,
    input wire logic [13:0][7:0] pad_in,
    output logic [13:0][7:0] pad_out,
    output logic [13:0][7:0] pad_oe_n,
    output logic [13:0][7:0] pad_pu_en,
    output logic [13:0][7:0] pad_pd_en,
    output logic [13:0][7:0] pad_slew_en,
    output logic [13:0][7:0] pin_level,
    output logic [13:0][7:0] wake_flag,
    output logic wake_irq_analog,
    output logic wake_irq_s,
    output logic wake_irq_t
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------

    // Reset asserts at once but releases two edges later, away from the edge
    gppw_sync_if #(.W(1)) rst_if ();
    logic rst_n;
    assign rst_if.raw = 1'b1;
    assign rst_n = rst_if.synced;

    gppw_sync #(.W(1)) u_rst_sync (
        .clk(clk),
        .rst_n(arst_n),
        .s(rst_if)
    );

    // ------------------------------------------------------------
    // Pad input synchroniser
    // ------------------------------------------------------------

    // Board signals are asynchronous; only the second stage is read below
    // The pin stages share the internal reset so no stale level outlives a reset
    gppw_sync_if #(.W(GPPW_NPORT * GPPW_W)) pin_if ();
    logic [13:0][7:0] lvl;
    assign pin_if.raw = pad_in;
    assign lvl = pin_if.synced;

    gppw_sync #(.W(GPPW_NPORT * GPPW_W)) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .s(pin_if)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    // Whole state is one packed struct of per-port register sets
    typedef struct packed {
        gppw_port_t [13:0] p;
    } gppw_state_t;

    gppw_state_t st_q;
    gppw_state_t st_d;

    // Reset image built from the per-port constants
    function automatic gppw_state_t gppw_reset_state();
        gppw_state_t r;
        r = '0;
        for (int i = 0; i < GPPW_NPORT; i++) begin
            r.p[i].out = GPPW_ZERO_RST;
            r.p[i].dir = GPPW_ZERO_RST;
            r.p[i].pen = GPPW_PEN_RST[i];
            r.p[i].pup = GPPW_PUP_RST[i];
            r.p[i].wen = GPPW_ZERO_RST;
            r.p[i].wpol = GPPW_ZERO_RST;
            r.p[i].od = GPPW_ZERO_RST;
            r.p[i].slew = GPPW_ZERO_RST;
            r.p[i].prev = GPPW_ZERO_RST;
            r.p[i].flag = GPPW_ZERO_RST;
        end
        return r;
    endfunction

    // Constant reset image; the reset branch below assigns nothing but this
    localparam gppw_state_t GPPW_RST_STATE = gppw_reset_state();

    // ------------------------------------------------------------
    // Field capability
    // ------------------------------------------------------------

    // Per-port write masks: absent pins and absent features are refused as zero
    logic [13:0][7:0] wake_cap;
    logic [13:0][7:0] od_cap;
    logic [13:0][7:0] slew_cap;

    // Capability follows the per-port feature constants and the pin mask
    always_comb begin
        for (int i = 0; i < GPPW_NPORT; i++) begin
            wake_cap[i] = GPPW_HAS_WAKE[i] ? GPPW_PIN_MASK[i] : 8'h00;
            od_cap[i] = GPPW_HAS_OD[i] ? GPPW_PIN_MASK[i] : 8'h00;
            slew_cap[i] = GPPW_HAS_SLEW[i] ? GPPW_PIN_MASK[i] : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // Config writes, edge capture and sticky wake flags for every port
    always_comb begin
        logic [7:0] m;
        logic [7:0] w;
        logic [7:0] rise;
        logic [7:0] fall;
        logic [7:0] hit;
        m = '0;
        w = '0;
        rise = '0;
        fall = '0;
        hit = '0;
        st_d = st_q;
        for (int i = 0; i < GPPW_NPORT; i++) begin
            m = GPPW_PIN_MASK[i];
            w = cfg_wdata & m;
            // Field writes; several ports may take the same field in one cycle
            if (cfg_wr[i]) begin
                case (cfg_sel)
                    GPPW_F_DATA: begin
                        st_d.p[i].out = w;
                    end
                    GPPW_F_DIR: begin
                        st_d.p[i].dir = w;
                    end
                    GPPW_F_PEN: begin
                        st_d.p[i].pen = w;
                    end
                    GPPW_F_PUP: begin
                        st_d.p[i].pup = w;
                    end
                    GPPW_F_WEN: begin
                        // Wake enables stick at zero on ports without wake-up
                        st_d.p[i].wen = cfg_wdata & wake_cap[i];
                    end
                    GPPW_F_WPOL: begin
                        st_d.p[i].wpol = cfg_wdata & wake_cap[i];
                    end
                    GPPW_F_OD: begin
                        st_d.p[i].od = cfg_wdata & od_cap[i];
                    end
                    GPPW_F_SLEW: begin
                        st_d.p[i].slew = cfg_wdata & slew_cap[i];
                    end
                    default: begin
                        st_d.p[i] = st_q.p[i];
                    end
                endcase
            end
            // Edge detection runs on the synchronised level
            st_d.p[i].prev = lvl[i] & m;
            rise = lvl[i] & ~st_q.p[i].prev & m;
            fall = ~lvl[i] & st_q.p[i].prev & m;
            // Polarity 0 wakes on a falling edge, 1 on a rising edge
            hit = ((rise & st_q.p[i].wpol) | (fall & ~st_q.p[i].wpol)) & st_q.p[i].wen;
            // A new edge in the clearing cycle is kept: set beats clear
            st_d.p[i].flag = ((st_q.p[i].flag & ~wake_clr[i]) | hit) & m;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= GPPW_RST_STATE;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Pad controls
    // ------------------------------------------------------------

    // Any flag of a port raises its request
    logic [13:0] port_wake;

    // Open-drain pins only pull low; a high is left to the pull-up or the board
    always_comb begin
        logic [7:0] drive;
        logic [7:0] od_rel;
        drive = '0;
        od_rel = '0;
        for (int i = 0; i < GPPW_NPORT; i++) begin
            // An open-drain pin holding a high lets go of the pad
            od_rel = st_q.p[i].od & st_q.p[i].out;
            drive = st_q.p[i].dir & ~od_rel;
            pad_out[i] = st_q.p[i].out & ~st_q.p[i].od;
            pad_oe_n[i] = ~drive;
            // Pull stays off while the pin is actively driven
            pad_pu_en[i] = st_q.p[i].pen & st_q.p[i].pup & ~drive;
            pad_pd_en[i] = st_q.p[i].pen & ~st_q.p[i].pup & ~drive;
            // Slew control can only be set on the slew-capable port
            pad_slew_en[i] = st_q.p[i].slew;
            // Read-back of the synchronised level and the sticky flags
            pin_level[i] = st_q.p[i].prev;
            wake_flag[i] = st_q.p[i].flag;
            port_wake[i] = |st_q.p[i].flag;
        end
    end

    // ------------------------------------------------------------
    // Wake request lines
    // ------------------------------------------------------------

    // One level line per wake-capable port; it stays up until every flag is cleared
    assign wake_irq_analog = port_wake[GPPW_P_ANALOG];
    assign wake_irq_s = port_wake[GPPW_P_S];
    assign wake_irq_t = port_wake[GPPW_P_T];

endmodule

// File: tb/gppw_pad_ctrl_properties.sv
// Concurrent checks on the pad control top ports.
// Assumes one clock and the asynchronous active-low reset of the top.
`timescale 1ns/1ps
module gppw_pad_ctrl_properties
    import gppw_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [13:0] cfg_wr,
    input wire gppw_field_t cfg_sel,
    input wire logic [7:0] cfg_wdata,
    input wire logic [13:0][7:0] wake_clr,
    input wire logic [13:0][7:0] pad_oe_n,
    input wire logic [13:0][7:0] pad_pu_en,
    input wire logic [13:0][7:0] pad_pd_en,
    input wire logic [13:0][7:0] pad_slew_en,
    input wire logic [13:0][7:0] wake_flag,
    input wire logic wake_irq_t
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Pull defaults are judged at the edge where reset lets go
    a_reset_pulls: assert property ($rose(arst_n) |-> &pad_oe_n
        && pad_pu_en == (GPPW_PEN_RST & GPPW_PUP_RST)
        && pad_pd_en == (GPPW_PEN_RST & ~GPPW_PUP_RST)) else $error("reset pulls wrong");
    a_pull_off_driven: assert property (((pad_pu_en | pad_pd_en) & ~pad_oe_n) == '0)
        else $error("pull active on driven pin");
    a_pull_one_side: assert property ((pad_pu_en & pad_pd_en) == '0)
        else $error("both pulls on");
    a_dir_write_a: assert property (cfg_wr[1] && cfg_sel == GPPW_F_DIR
        |=> pad_oe_n[1] == ~$past(cfg_wdata)) else $error("direction not applied");
    a_slew_write_u: assert property (cfg_wr[13] && cfg_sel == GPPW_F_SLEW
        |=> pad_slew_en[13] == $past(cfg_wdata)) else $error("slew not applied");
    a_slew_only_u: assert property (pad_slew_en[12:0] == '0)
        else $error("slew on wrong port");
    a_wake_three_ports: assert property (wake_flag[10:1] == '0 && wake_flag[13] == '0)
        else $error("wake flag on plain port");
    a_wake_flag_sticky: assert property (wake_flag[12][0] && !wake_clr[12][0]
        |=> wake_flag[12][0]) else $error("wake flag lost");
    a_wake_irq_or: assert property (wake_irq_t == |wake_flag[12])
        else $error("wake request mismatch");
endmodule

bind gppw_pad_ctrl gppw_pad_ctrl_properties u_props (.clk(clk), .arst_n(arst_n),
    .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata), .wake_clr(wake_clr),
    .pad_oe_n(pad_oe_n), .pad_pu_en(pad_pu_en), .pad_pd_en(pad_pd_en),
    .pad_slew_en(pad_slew_en), .wake_flag(wake_flag), .wake_irq_t(wake_irq_t));

// File: tb/gppw_board_model.sv
// Board side of the pads: external drivers, pull resistors and floating nodes.
// Assumes the pad enables come straight from the pad control top.
`timescale 1ns/1ps
module gppw_board_model (
    input wire logic [13:0][7:0] pad_out,
    input wire logic [13:0][7:0] pad_oe_n,
    input wire logic [13:0][7:0] pad_pu_en,
    input wire logic [13:0][7:0] pad_pd_en,
    input wire logic [13:0][7:0] ext_en,
    input wire logic [13:0][7:0] ext_val,
    output logic [13:0][7:0] pad_in
);
    // Own drive wins, then the board, then a pull; a floating node shows the
    // inverse of the board value so a stale level is never taken for a pull
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ((ext_en & ext_val)
        | (~ext_en & (pad_pu_en | (~pad_pd_en & ~ext_val)))));
endmodule

// File: tb/testbench.sv
// Self-checking bench for the pad control block.
// Assumes the bound checker and the board model beside the design.
`timescale 1ns/1ps
module testbench;
    import gppw_pkg::*;
    typedef struct packed {
        logic [3:0] lane;
        gppw_field_t sel;
        logic [7:0] wdata;
        logic [2:0] chk;
        logic [7:0] exp;
    } gppw_row_t;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [13:0] cfg_wr = '0;
    gppw_field_t cfg_sel = GPPW_F_DATA;
    logic [7:0] cfg_wdata = 8'h00;
    logic [13:0][7:0] wake_clr = '0;
    logic [13:0][7:0] ext_en = '1;
    logic [13:0][7:0] ext_val = '1;
    logic [13:0][7:0] pad_in, pad_out, pad_oe_n, pad_pu_en, pad_pd_en;
    logic [13:0][7:0] pad_slew_en, pin_level, wake_flag;
    logic wake_irq_analog, wake_irq_s, wake_irq_t;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    // Check codes: 0 oe_n, 1 pull-up, 2 pull-down, 3 slew, 4 drive value
    localparam gppw_row_t ROWS [15] = '{
        '{4'h1, GPPW_F_DIR, 8'ha5, 3'h0, 8'h5a},
        '{4'h1, GPPW_F_PEN, 8'hff, 3'h2, 8'h5a},
        '{4'h1, GPPW_F_DATA, 8'h3c, 3'h4, 8'h3c},
        '{4'h3, GPPW_F_PUP, 8'h0f, 3'h1, 8'h00},
        '{4'h3, GPPW_F_PEN, 8'hff, 3'h1, 8'h0f},
        '{4'h3, GPPW_F_PEN, 8'hff, 3'h2, 8'hf0},
        '{4'h2, GPPW_F_DIR, 8'hff, 3'h0, 8'hf0},
        '{4'h7, GPPW_F_PEN, 8'hff, 3'h2, 8'h0f},
        '{4'hd, GPPW_F_SLEW, 8'h81, 3'h3, 8'h81},
        '{4'h4, GPPW_F_SLEW, 8'hff, 3'h3, 8'h00},
        '{4'hb, GPPW_F_OD, 8'h01, 3'h0, 8'hff},
        '{4'hb, GPPW_F_DIR, 8'h03, 3'h0, 8'hfc},
        '{4'hb, GPPW_F_DATA, 8'h03, 3'h0, 8'hfd},
        '{4'hb, GPPW_F_DATA, 8'h03, 3'h1, 8'hfd},
        '{4'hb, GPPW_F_DATA, 8'h03, 3'h4, 8'h02}
    };

    gppw_pad_ctrl u_dut (.clk(clk), .arst_n(arst_n), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
        .cfg_wdata(cfg_wdata), .wake_clr(wake_clr), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .pad_pu_en(pad_pu_en), .pad_pd_en(pad_pd_en),
        .pad_slew_en(pad_slew_en), .pin_level(pin_level), .wake_flag(wake_flag),
        .wake_irq_analog(wake_irq_analog), .wake_irq_s(wake_irq_s), .wake_irq_t(wake_irq_t));
    gppw_board_model u_board (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pu_en(pad_pu_en),
        .pad_pd_en(pad_pd_en), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    initial begin
        forever #2.5 clk = ~clk;
    end
    // The whole run needs under 70 cycles; a hang is cut well past that
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One write, then an idle cycle so the strobe never toggles twice at once
    task automatic wr(input logic [13:0] ports, input gppw_field_t sel, input logic [7:0] d);
        cfg_wr = ports;
        cfg_sel = sel;
        cfg_wdata = d;
        @(negedge clk);
        cfg_wr = '0;
        @(negedge clk);
    endtask
    function automatic logic [7:0] pick(input logic [2:0] c, input logic [3:0] l);
        case (c)
            3'h0: pick = pad_oe_n[l];
            3'h1: pick = pad_pu_en[l];
            3'h2: pick = pad_pd_en[l];
            3'h3: pick = pad_slew_en[l];
            default: pick = pad_out[l];
        endcase
    endfunction
    // Pull-downs on A,B,D,E,F,G,H, pull-ups on S, nothing else pulled
    task automatic chk_reset();
        for (int p = 0; p < GPPW_NPORT; p++) begin
            check(pad_pd_en[p], (p inside {1, 4, 6, 8, 9}) ? 8'hff
                : (p inside {2, 5}) ? 8'h0f : 8'h00);
            check(pad_pu_en[p], (p == 11) ? 8'hff : 8'h00);
            check(pad_oe_n[p], 8'hff);
        end
    endtask
    task automatic print_verdict();
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(negedge clk);
        chk_reset();
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        foreach (ROWS[i]) begin
            wr(14'h0001 << ROWS[i].lane, ROWS[i].sel, ROWS[i].wdata);
            check(pick(ROWS[i].chk, ROWS[i].lane), ROWS[i].exp);
        end
        // Wake enable goes to a plain port and a wake port in one write
        wr(14'h1002, GPPW_F_WEN, 8'hff);
        ext_val[12] = 8'hfe;
        ext_val[1] = 8'h00;
        repeat (5) @(negedge clk);
        check(wake_flag[12], 8'h01);
        check({7'h00, wake_irq_t}, 8'h01);
        check(wake_flag[1], 8'h00);
        check(pin_level[1], 8'h24);
        wake_clr[12] = 8'h01;
        @(negedge clk);
        wake_clr[12] = 8'h00;
        @(negedge clk);
        check(wake_flag[12], 8'h00);
        check({7'h00, wake_irq_t}, 8'h00);
        // Rising polarity on analog and S: a fall is ignored, a rise is caught
        wr(14'h0801, GPPW_F_WPOL, 8'h80);
        wr(14'h0801, GPPW_F_WEN, 8'h80);
        ext_val[0] = 8'h7f;
        ext_val[11] = 8'h7f;
        repeat (5) @(negedge clk);
        check(wake_flag[0], 8'h00);
        check({7'h00, wake_irq_s}, 8'h00);
        ext_val[0] = 8'hff;
        ext_val[11] = 8'hff;
        repeat (5) @(negedge clk);
        check(wake_flag[0], 8'h80);
        check(wake_flag[11], 8'h80);
        check({7'h00, wake_irq_analog}, 8'h01);
        check({7'h00, wake_irq_s}, 8'h01);
        // Reset in mid-run must bring back every pull default
        arst_n = 1'b0;
        @(negedge clk);
        chk_reset();
        check({6'h00, wake_irq_analog, wake_irq_s}, 8'h00);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        print_verdict();
    end
endmodule
